// ===== hdl/ttp_host_port.v
// Host register port of the tone transceiver
//
// Behaviour
// - Exactly five registers reachable through the host port.
// - Received code is read-only, holding the last validated digit.
// - Transmit code is write-only and selects the generated tone pair.
// - Both control registers share one address; sequencing picks the target.
// - Bank select high sends next control write to secondary, then back.
// - Status is read-only and reports current transceiver flags.
// - Select low with write strobe latches data into transmit code.
// - Select high with write strobe latches data into selected control.
// - Select low with read strobe drives received code onto the bus.
// - Select high with read strobe drives status onto the bus.
// - Host bus cycles complete without wait states if strobes stay low past the two-stage pin synchronisers.
// - Tone output enable on enables transmit tone; off silences all.
// - Progress mode on selects call progress; off selects DTMF.
// - Call progress with interrupt enable shows squared tone on pin.
// - Call-progress mode never latches incoming DTMF digits.
// - DTMF with interrupt enable and test bit clear pulls pin low on digit or empty.
// - Single-tone mode generates one low- or high-group tone.
// - Secondary bit 0 low enables burst; each transmit write while idle bursts, pauses, flags.
// - Status bit 0 set when bit 1 or 2 set; read clears.
// - Status bit 1 set after burst pause; cleared by read or non-burst.
// - Status bit 2 set on received code latch; read clears.
`include "ttp_defs.vh"

module ttp_host_port
#(
	parameter [20:0] BURST_CYC = `TTP_BURST_CYC
)
(
	// Clock and reset
	input  wire        ref_clk_i,
	input  wire        rst_n_i,
	// Host bus pins
	input  wire        reg_select_line_i,
	input  wire        write_strobe_n_i,
	input  wire        read_strobe_n_i,
	input  wire [3:0]  data_i,
	output wire [3:0]  data_o,
	output wire        data_oe_o,
	// Interrupt or call-progress pin, open drain
	output wire        irq_or_tone_pin_o,
	output wire        irq_or_tone_pin_oe_o,
	// Receiver side
	input  wire        rx_valid_i,
	input  wire [3:0]  rx_code_i,
	input  wire        rx_steer_i,
	input  wire        cp_tone_i,
	// Tone generator side
	output wire [3:0]  tx_code_o,
	output wire        tx_tone_on_o,
	output wire        tx_single_o,
	output wire        tx_column_o
);

	// ----------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------
	reg  [1:0] rst_sync_ff;
	wire       rst_n;
	reg  [1:0] sel_sync_ff;
	reg  [1:0] wr_sync_ff;
	reg  [1:0] rd_sync_ff;
	reg  [1:0] rxv_sync_ff;
	reg  [1:0] stg_sync_ff;
	reg  [1:0] cpt_sync_ff;
	reg  [3:0] din_s1_ff;
	reg  [3:0] din_s2_ff;
	reg  [3:0] rxc_s1_ff;
	reg  [3:0] rxc_s2_ff;

	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_sync_ff <= 2'h0;
		end
		else
		begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// Strobes idle high so synchronisers reset to the idle level
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_sync_ff <= 2'h0;
			wr_sync_ff  <= 2'h3;
			rd_sync_ff  <= 2'h3;
			rxv_sync_ff <= 2'h0;
			stg_sync_ff <= 2'h0;
			cpt_sync_ff <= 2'h0;
			din_s1_ff   <= 4'h0;
			din_s2_ff   <= 4'h0;
			rxc_s1_ff   <= 4'h0;
			rxc_s2_ff   <= 4'h0;
		end
		else
		begin
			sel_sync_ff <= {sel_sync_ff[0], reg_select_line_i};
			wr_sync_ff  <= {wr_sync_ff[0], write_strobe_n_i};
			rd_sync_ff  <= {rd_sync_ff[0], read_strobe_n_i};
			rxv_sync_ff <= {rxv_sync_ff[0], rx_valid_i};
			stg_sync_ff <= {stg_sync_ff[0], rx_steer_i};
			cpt_sync_ff <= {cpt_sync_ff[0], cp_tone_i};
			din_s1_ff   <= data_i;
			din_s2_ff   <= din_s1_ff;
			rxc_s1_ff   <= rx_code_i;
			rxc_s2_ff   <= rxc_s1_ff;
		end
	end

	// ----------------------------------------
	// Bus cycle decode
	// ----------------------------------------
	reg        wr_d_ff;
	reg        rd_d_ff;
	reg        rxv_d_ff;
	reg        rd_sel_ff;
	wire       wr_act;
	wire       rd_act;
	wire       wr_end;
	wire       rd_end;
	wire       rx_event;

	// Only one strobe low is a valid cycle
	assign wr_act   = !wr_sync_ff[1] && rd_sync_ff[1];
	assign rd_act   = !rd_sync_ff[1] && wr_sync_ff[1];
	// Data sampled at the rising write strobe, where setup is guaranteed
	assign wr_end   = wr_d_ff && !wr_act;
	assign rd_end   = rd_d_ff && !rd_act;
	assign rx_event = rxv_sync_ff[1] && !rxv_d_ff;

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_d_ff   <= 1'b0;
			rd_d_ff   <= 1'b0;
			rxv_d_ff  <= 1'b0;
			rd_sel_ff <= 1'b0;
		end
		else
		begin
			wr_d_ff  <= wr_act;
			rd_d_ff  <= rd_act;
			rxv_d_ff <= rxv_sync_ff[1];
			if (rd_act)
			begin
				rd_sel_ff <= sel_sync_ff[1];
			end
		end
	end

	// ----------------------------------------
	// Write side registers
	// ----------------------------------------
	reg  [3:0] tx_code_ff;
	reg  [3:0] primary_ff;
	reg  [3:0] secondary_ff;
	reg        bank_ff;
	reg        wr_sel_ff;
	reg  [3:0] wr_data_ff;
	wire       burst_on;
	wire       tx_start;

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_sel_ff  <= 1'b0;
			wr_data_ff <= 4'h0;
		end
		else if (wr_act)
		begin
			wr_sel_ff  <= sel_sync_ff[1];
			wr_data_ff <= din_s2_ff;
		end
	end

	assign tx_start = wr_end && (wr_sel_ff == `TTP_SEL_DATA);

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_code_ff   <= `TTP_RST_CODE;
			primary_ff   <= `TTP_RST_PRIMARY;
			secondary_ff <= `TTP_RST_SECONDARY;
			bank_ff      <= 1'b0;
		end
		else if (wr_end)
		begin
			if (wr_sel_ff == `TTP_SEL_DATA)
			begin
				tx_code_ff <= wr_data_ff;
			end
			else if (bank_ff)
			begin
				secondary_ff <= wr_data_ff;
				bank_ff      <= 1'b0;
			end
			else
			begin
				primary_ff <= wr_data_ff;
				bank_ff    <= wr_data_ff[`TTP_PC_BANK_SEL];
			end
		end
	end

	// ----------------------------------------
	// Burst sequencing
	// ----------------------------------------
	wire       burst_tone;
	wire       burst_done;
	wire       progress;

	assign progress = primary_ff[`TTP_PC_PROGRESS];
	assign burst_on = !secondary_ff[`TTP_SC_BURST_OFF];

	ttp_burst_timer #(
		.BURST_CYC (BURST_CYC)
	) u_burst (
		.clk_i     (ref_clk_i),
		.rst_n_i   (rst_n),
		.start_i   (tx_start),
		.enable_i  (burst_on),
		.double_i  (progress),
		.tone_on_o (burst_tone),
		.done_o    (burst_done)
	);

	// ----------------------------------------
	// Receive code and status flags
	// ----------------------------------------
	reg  [3:0] rx_code_ff;
	reg        tx_empty_ff;
	reg        rx_full_ff;
	reg  [3:0] dout_ff;
	wire       st_clr;
	wire [3:0] status;

	// Clear at the end of the read so the returned value is pre-clear
	assign st_clr = rd_end && rd_sel_ff;

	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_code_ff  <= `TTP_RST_CODE;
			tx_empty_ff <= 1'b0;
			rx_full_ff  <= 1'b0;
		end
		else
		begin
			if (rx_event && !progress)
			begin
				rx_code_ff <= rxc_s2_ff;
			end
			// Set wins over a clear in the same cycle
			if (rx_event && !progress)
			begin
				rx_full_ff <= 1'b1;
			end
			else if (st_clr)
			begin
				rx_full_ff <= 1'b0;
			end
			if (!burst_on)
			begin
				tx_empty_ff <= 1'b0;
			end
			else if (burst_done)
			begin
				tx_empty_ff <= 1'b1;
			end
			else if (st_clr)
			begin
				tx_empty_ff <= 1'b0;
			end
		end
	end

	assign status = {stg_sync_ff[1], rx_full_ff, tx_empty_ff,
		tx_empty_ff | rx_full_ff};

	// Read data captured while the strobe is low; no wait states needed
	always @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dout_ff <= 4'h0;
		end
		else if (rd_act)
		begin
			dout_ff <= sel_sync_ff[1] ? status : rx_code_ff;
		end
	end

	assign data_o    = dout_ff;
	assign data_oe_o = rd_act;

	// ----------------------------------------
	// Tone control and shared pin
	// ----------------------------------------
	wire       tone_en;
	wire       irq_en;
	wire       test_en;
	wire       pin_low;

	assign tone_en      = primary_ff[`TTP_PC_TONE_OUT];
	assign irq_en       = primary_ff[`TTP_PC_IRQ_EN];
	assign test_en      = secondary_ff[`TTP_SC_TEST];
	assign tx_code_o    = tx_code_ff;
	assign tx_tone_on_o = tone_en && (!burst_on || burst_tone);
	assign tx_single_o  = secondary_ff[`TTP_SC_SINGLE];
	assign tx_column_o  = secondary_ff[`TTP_SC_COLUMN];

	// Open drain: pin low when driven, high through the pull-up
	assign pin_low = !irq_en ? 1'b0 :
		progress ? !cpt_sync_ff[1] :
		test_en ? !stg_sync_ff[1] :
		(rx_full_ff || tx_empty_ff);

	assign irq_or_tone_pin_o    = 1'b0;
	assign irq_or_tone_pin_oe_o = pin_low;

endmodule

// ===== hdl/ttp_defs.vh
// Constants of the tone transceiver host port
`ifndef TTP_DEFS_VH
`define TTP_DEFS_VH

// ----------------------------------------
// Register select decode
// ----------------------------------------
`define TTP_SEL_DATA        1'b0
`define TTP_SEL_CTRL        1'b1

// ----------------------------------------
// Primary control fields
// ----------------------------------------
`define TTP_PC_TONE_OUT     0
`define TTP_PC_PROGRESS     1
`define TTP_PC_IRQ_EN       2
`define TTP_PC_BANK_SEL     3

// ----------------------------------------
// Secondary control fields
// ----------------------------------------
`define TTP_SC_BURST_OFF    0
`define TTP_SC_TEST         1
`define TTP_SC_SINGLE       2
`define TTP_SC_COLUMN       3

// ----------------------------------------
// Status fields
// ----------------------------------------
`define TTP_ST_IRQ          0
`define TTP_ST_TX_EMPTY     1
`define TTP_ST_RX_FULL      2
`define TTP_ST_DLY_STEER    3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TTP_RST_PRIMARY     4'h0
`define TTP_RST_SECONDARY   4'h0
`define TTP_RST_CODE        4'h0

// ----------------------------------------
// Burst timing, 10 MHz clock
// ----------------------------------------
`define TTP_CLK_HZ          10000000
`define TTP_BURST_MS        51
// 51 ms at 10 MHz, sized to the 21-bit timer parameter
`define TTP_BURST_CYC       21'd510000
`define TTP_CNT_W           21

`endif

// ===== hdl/ttp_burst_timer.v
// Burst and pause sequencer for the transmit tone
`include "ttp_defs.vh"

module ttp_burst_timer
#(
	parameter [20:0] BURST_CYC = `TTP_BURST_CYC
)
(
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_n_i,
	// Control
	input  wire        start_i,
	input  wire        enable_i,
	input  wire        double_i,
	// Status
	output wire        tone_on_o,
	output wire        done_o
);

	localparam [1:0] ST_IDLE  = 2'd0;
	localparam [1:0] ST_BURST = 2'd1;
	localparam [1:0] ST_PAUSE = 2'd2;

	reg  [1:0]                state_ff;
	reg  [1:0]                nxt_state;
	reg  [`TTP_CNT_W:0]       cnt_ff;
	reg  [`TTP_CNT_W:0]       nxt_cnt;
	reg                       done_ff;
	reg                       nxt_done;
	wire [`TTP_CNT_W:0]       limit;

	// Call-progress mode doubles both burst and pause
	assign limit = double_i ? {BURST_CYC, 1'b0} : {1'b0, BURST_CYC};

	always @*
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_done  = 1'b0;
		if (!enable_i)
		begin
			nxt_state = ST_IDLE;
			nxt_cnt   = {(`TTP_CNT_W+1){1'b0}};
		end
		else
		begin
			case (state_ff)
			ST_IDLE:
			begin
				if (start_i)
				begin
					nxt_state = ST_BURST;
					nxt_cnt   = {(`TTP_CNT_W+1){1'b0}};
				end
			end
			ST_BURST, ST_PAUSE:
			begin
				if (cnt_ff >= limit - 1'b1)
				begin
					nxt_cnt = {(`TTP_CNT_W+1){1'b0}};
					if (state_ff == ST_BURST)
					begin
						nxt_state = ST_PAUSE;
					end
					else
					begin
						nxt_state = ST_IDLE;
						nxt_done  = 1'b1;
					end
				end
				else
				begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
			endcase
		end
	end

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= ST_IDLE;
			cnt_ff   <= {(`TTP_CNT_W+1){1'b0}};
			done_ff  <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			done_ff  <= nxt_done;
		end
	end

	assign tone_on_o = (state_ff == ST_BURST);
	assign done_o    = done_ff;

endmodule

// ===== dv/ttp_host_port_assertions.sv
// Pin-level checker for the tone transceiver host port
module ttp_host_port_chk
#(
	parameter [20:0] BURST_CYC = 21'd20
)
(
	// Clock and reset
	input wire       ref_clk_i,
	input wire       rst_n_i,
	// Host bus
	input wire       reg_select_line_i,
	input wire       write_strobe_n_i,
	input wire       read_strobe_n_i,
	input wire [3:0] data_i,
	input wire [3:0] data_o,
	input wire       data_oe_o,
	input wire       irq_or_tone_pin_o,
	input wire       irq_or_tone_pin_oe_o,
	// Receiver and generator
	input wire       rx_valid_i,
	input wire [3:0] rx_code_i,
	input wire       rx_steer_i,
	input wire       cp_tone_i,
	input wire [3:0] tx_code_o,
	input wire       tx_tone_on_o,
	input wire       tx_single_o,
	input wire       tx_column_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Last select and data under the write strobe
	// ----
	logic       sel_wr_ff;
	logic [3:0] dat_wr_ff;
	always @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sel_wr_ff <= 1'b0;
			dat_wr_ff <= 4'h0;
		end
		else if (!write_strobe_n_i)
		begin
			sel_wr_ff <= reg_select_line_i;
			dat_wr_ff <= data_i;
		end
	end
	default clocking cb_main @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ----
	// Properties
	// ----
	a_pin_pulls_low: assert property (irq_or_tone_pin_o == 1'b0)
		else $error("tone pin drives high");
	a_oe_on_read: assert property ($fell(read_strobe_n_i) && write_strobe_n_i
		|-> ##[1:3] data_oe_o) else $error("read not answered");
	a_oe_idle_off: assert property (read_strobe_n_i [*4] |-> !data_oe_o)
		else $error("bus driven without read");
	a_oe_cause: assert property ($rose(data_oe_o) |-> $past(read_strobe_n_i, 2) == 1'b0
		&& $past(write_strobe_n_i, 2)) else $error("bus driven early");
	a_read_no_side: assert property (data_oe_o
		|-> $stable(tx_code_o) && $stable({tx_single_o, tx_column_o}))
		else $error("read changed a register");
	a_tx_from_wr: assert property ($changed(tx_code_o)
		|-> !sel_wr_ff && tx_code_o == dat_wr_ff && write_strobe_n_i)
		else $error("transmit code changed wrongly");
	a_ctrl_from_wr: assert property ($changed({tx_single_o, tx_column_o})
		|-> sel_wr_ff && write_strobe_n_i) else $error("control changed wrongly");
	a_tone_after_wr: assert property ($rose(tx_tone_on_o)
		|-> write_strobe_n_i && read_strobe_n_i) else $error("tone started mid cycle");
	c_tx_write: cover property ($changed(tx_code_o));
	c_read: cover property ($rose(data_oe_o));
	c_pin_low: cover property ($rose(irq_or_tone_pin_oe_o));
endmodule

// ===== dv/ttp_host_model.sv
// Host microcontroller model for the multiplexed register bus
module ttp_host_model
(
	input  wire        ref_clk_i,
	input  wire  [3:0] bus_rd_i,
	input  wire        bus_oe_i,
	output logic       sel_o,
	output logic       wr_n_o,
	output logic       rd_n_o,
	output logic [3:0] bus_wr_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		sel_o = 1'b0;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		bus_wr_o = 4'h0;
	end
	// Strobes are pins sampled by the device clock, so hold them long
	task automatic wr(input logic sel, input logic [3:0] val);
		@(negedge ref_clk_i);
		sel_o = sel;
		bus_wr_o = val;
		wr_n_o = 1'b0;
		repeat (5) @(negedge ref_clk_i);
		wr_n_o = 1'b1;
		repeat (5) @(negedge ref_clk_i);
		bus_wr_o = ~val; // Released bus loses its value
	endtask
	task automatic rd(input logic sel, output logic [3:0] val);
		@(negedge ref_clk_i);
		sel_o = sel;
		rd_n_o = 1'b0;
		repeat (5) @(negedge ref_clk_i);
		val = bus_oe_i ? bus_rd_i : 4'hx;
		rd_n_o = 1'b1;
		repeat (5) @(negedge ref_clk_i);
	endtask
endmodule

// ===== dv/tb_ttp_host_port.sv
// Testbench top for the tone transceiver host port
module tb_ttp_host_port;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [20:0] BURST_CYC = 21'd20;
	logic       ref_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       sel, wr_n, rd_n, oe, pin, pin_oe, tone, single, column;
	logic [3:0] dat_w, dat_r, tx_code, v;
	logic       rx_valid = 1'b0;
	logic [3:0] rx_code = 4'h0;
	logic       rx_steer = 1'b1;
	logic       cp_tone = 1'b1;
	int         errors = 0;
	int         n_checks = 0;
	always #50 ref_clk = ~ref_clk;
	ttp_host_model u_host (.ref_clk_i(ref_clk), .bus_rd_i(dat_r), .bus_oe_i(oe),
		.sel_o(sel), .wr_n_o(wr_n), .rd_n_o(rd_n), .bus_wr_o(dat_w));
	ttp_host_port #(.BURST_CYC(BURST_CYC)) u_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
		.reg_select_line_i(sel), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
		.data_i(dat_w), .data_o(dat_r), .data_oe_o(oe), .irq_or_tone_pin_o(pin),
		.irq_or_tone_pin_oe_o(pin_oe), .rx_valid_i(rx_valid), .rx_code_i(rx_code),
		.rx_steer_i(rx_steer), .cp_tone_i(cp_tone), .tx_code_o(tx_code),
		.tx_tone_on_o(tone), .tx_single_o(single), .tx_column_o(column));
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Code settles before the valid edge; steering drops for the digit
	task automatic digit(input logic [3:0] c);
		@(negedge ref_clk);
		rx_code = c;
		rx_steer = 1'b0;
		repeat (4) @(negedge ref_clk);
		rx_valid = 1'b1;
		repeat (4) @(negedge ref_clk);
		rx_valid = 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic wait_pin;
		int k;
		for (k = 0; k < 300 && pin_oe !== 1'b1; k++)
			@(negedge ref_clk);
		if (pin_oe !== 1'b1)
		begin
			errors++;
			conclude();
		end
	endtask
	initial
	begin
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		u_host.rd(1'b1, v);
		u_host.wr(1'b1, 4'h8);
		check({3'h0, column}, 4'h0);
		u_host.wr(1'b1, 4'hc);
		check({2'h0, single, column}, 4'h3);
		u_host.wr(1'b1, 4'h0);
		u_host.wr(1'b1, 4'h0);
		check({2'h0, single, column}, 4'h3);
		u_host.wr(1'b1, 4'h8);
		u_host.wr(1'b1, 4'h1);
		check({2'h0, single, column}, 4'h0);
		u_host.wr(1'b1, 4'h1);
		check({3'h0, tone}, 4'h1);
		u_host.wr(1'b1, 4'h0);
		check({3'h0, tone}, 4'h0);
		for (int i = 0; i < 16; i++)
		begin
			u_host.wr(1'b0, 4'(i));
			check(tx_code, 4'(i));
		end
		check({3'h0, tone}, 4'h0);
		u_host.rd(1'b1, v);
		check(v, 4'h8);
		u_host.wr(1'b1, 4'h4);
		digit(4'h9);
		check({3'h0, pin_oe}, 4'h1);
		u_host.rd(1'b0, v);
		check(v, 4'h9);
		u_host.rd(1'b1, v);
		check(v, 4'h5);
		check({3'h0, pin_oe}, 4'h0);
		u_host.rd(1'b1, v);
		check(v, 4'h0);
		rx_steer = 1'b1;
		u_host.wr(1'b1, 4'h6);
		digit(4'h3);
		u_host.rd(1'b1, v);
		check(v, 4'h0);
		u_host.rd(1'b0, v);
		check(v, 4'h9);
		cp_tone = 1'b0;
		repeat (4) @(negedge ref_clk);
		check({3'h0, pin_oe}, 4'h1);
		cp_tone = 1'b1;
		repeat (4) @(negedge ref_clk);
		check({3'h0, pin_oe}, 4'h0);
		rx_steer = 1'b1;
		u_host.wr(1'b1, 4'h8);
		u_host.wr(1'b1, 4'h0);
		u_host.wr(1'b1, 4'h5);
		u_host.wr(1'b0, 4'h2);
		check({3'h0, tone}, 4'h1);
		wait_pin();
		check({3'h0, tone}, 4'h0);
		u_host.rd(1'b1, v);
		check(v, 4'hb);
		check({3'h0, pin_oe}, 4'h0);
		u_host.wr(1'b0, 4'h7);
		wait_pin();
		// Call progress doubles the burst; tone still on past one base burst
		u_host.wr(1'b1, 4'h7);
		u_host.rd(1'b1, v);
		check(v, 4'hb);
		u_host.wr(1'b0, 4'h1);
		repeat (25) @(negedge ref_clk);
		check({3'h0, tone}, 4'h1);
		repeat (70) @(negedge ref_clk);
		u_host.rd(1'b1, v);
		check(v, 4'hb);
		u_host.wr(1'b1, 4'h8);
		u_host.wr(1'b1, 4'h1);
		u_host.rd(1'b1, v);
		check(v & 4'h2, 4'h0);
		// Test mode puts steering on the pin
		u_host.wr(1'b1, 4'h8);
		u_host.wr(1'b1, 4'h3);
		u_host.wr(1'b1, 4'h4);
		check({3'h0, pin_oe}, 4'h0);
		rx_steer = 1'b0;
		repeat (4) @(negedge ref_clk);
		check({3'h0, pin_oe}, 4'h1);
		conclude();
	end
endmodule
bind ttp_host_port ttp_host_port_chk #(.BURST_CYC(BURST_CYC)) u_chk (
	.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_select_line_i(reg_select_line_i),
	.write_strobe_n_i(write_strobe_n_i), .read_strobe_n_i(read_strobe_n_i),
	.data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
	.irq_or_tone_pin_o(irq_or_tone_pin_o), .irq_or_tone_pin_oe_o(irq_or_tone_pin_oe_o),
	.rx_valid_i(rx_valid_i), .rx_code_i(rx_code_i), .rx_steer_i(rx_steer_i),
	.cp_tone_i(cp_tone_i), .tx_code_o(tx_code_o), .tx_tone_on_o(tx_tone_on_o),
	.tx_single_o(tx_single_o), .tx_column_o(tx_column_o));
